// [src/isf_status_flags.sv]
//Contract
//RQ1: master transmit records slave ack or nack
//RQ2: transmit busy from start until slave ack
//RQ3: bus collision flag sticky until software clears
//RQ4: general call flag set on match, stop clears
//RQ5: ten bit flag on second byte match
//RQ6: busy transmit write dropped, write collision flagged
//RQ7: byte over unread holding sets overflow
//RQ8: data flag cleared on address, set on data (code sets it only on bytes received in slave mode)
//RQ9: stop flag set by stop, cleared by start
//RQ10: start flag set by start, cleared by stop
//RQ11: direction flag loaded from address byte
//RQ12: receive full set on load, read clears
//RQ13: transmit full set on write, cleared when sent
//RQ14: unimplemented status bits read as zero
//RQ15: ten bit mode selects address width
//RQ16: general call only when enabled
//RQ17: reset zeroes flags, clears touch only target
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module isf_status_flags
    import isf_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        scl_pin_in,
    input  wire logic        sda_pin_in,
    input  wire logic [4:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [31:0]      reg_rdata_out,
    output logic             irq_out,
    input  wire logic        master_mode_in,
    input  wire logic        master_rx_in,
    input  wire logic        master_tx_start_in,
    input  wire logic        sda_release_in,
    output logic [7:0]       tx_data_out,
    output logic             tx_full_out
);
    logic [1:0]            pins_f;
    logic                  start_p;
    logic                  stop_p;
    logic                  byte_p;
    logic [7:0]            byte_v;
    logic                  ack_p;
    logic                  ack_v;

    logic                  ack_status_ff;
    logic                  tx_busy_ff;
    logic                  bcl_ff;
    logic                  gc_ff;
    logic                  t10_ff;
    logic                  wcol_ff;
    logic                  ov_ff;
    logic                  da_ff;
    logic                  p_ff;
    logic                  s_ff;
    logic                  rw_ff;
    logic                  rbf_ff;
    logic                  tbf_ff;
    logic [CTL_W-1:0]      ctl_ff;
    logic [OWN_ADDR_W-1:0] own_ff;
    logic [7:0]            rx_hold_ff;
    logic [EV_W-1:0]       ev_ff;
    logic [EV_W-1:0]       mask_ff;
    isf_slv_state_t        state_ff;
    isf_slv_state_t        nxt_state;
    logic                  addr_hit;
    logic                  hit_rw;
    logic                  gc_hit;
    logic                  t10_hit;

    isf_pin_sync #(
        .WIDTH (2)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .pin_in     ({scl_pin_in, sda_pin_in}),
        .level_out  (pins_f)
    );

    isf_bit_engine u_bits (
        .ref_clk_in   (ref_clk_in),
        .rstn_in      (rstn_in),
        .scl_in       (pins_f[1]),
        .sda_in       (pins_f[0]),
        .start_out    (start_p),
        .stop_out     (stop_p),
        .byte_out     (byte_p),
        .byte_val_out (byte_v),
        .ack_out      (ack_p),
        .ack_val_out  (ack_v)
    );

    // register port decode
    wire wr_status = reg_wr_in & (reg_addr_in == OFF_STATUS);
    wire wr_ctl    = reg_wr_in & (reg_addr_in == OFF_CONTROL);
    wire wr_own    = reg_wr_in & (reg_addr_in == OFF_OWN_ADDR);
    wire wr_tx     = reg_wr_in & (reg_addr_in == OFF_TX_HOLD);
    wire wr_mask   = reg_wr_in & (reg_addr_in == OFF_IRQ_MASK);
    wire rd_rx     = reg_rd_in & (reg_addr_in == OFF_RX_HOLD);
    wire rd_irq    = reg_rd_in & (reg_addr_in == OFF_IRQ_STAT);
    wire [15:0] clr = wr_status ? (~reg_wdata_in[15:0] & STATUS_CLR_MASK)
                                : 16'h0000;
    wire ten_mode  = ctl_ff[CTL_TEN_BIT];
    wire gc_en     = ctl_ff[CTL_GC_EN];

    // slave address tracking
    wire hdr10    = (byte_v[7:3] == TEN_HDR) &
                    (byte_v[2:1] == own_ff[9:8]);
    wire own7     = (byte_v[7:1] == own_ff[6:0]);
    always_comb
    begin
        nxt_state = state_ff;
        addr_hit  = 1'b0;
        hit_rw    = 1'b0;
        gc_hit    = 1'b0;
        t10_hit   = 1'b0;
        case (state_ff)
            ISF_SL_ADDR:
            begin
                if (byte_p)
                begin
                    nxt_state = ISF_SL_SKIP;
                    if (gc_en & (byte_v == GC_ADDR)) // RQ16
                    begin
                        gc_hit    = 1'b1; // RQ4
                        addr_hit  = 1'b1;
                        nxt_state = ISF_SL_DATA;
                    end
                    else if (ten_mode) // RQ15
                    begin
                        if (hdr10 & ~byte_v[0])
                        begin
                            nxt_state = ISF_SL_ADDR2;
                        end
                        else if (hdr10 & t10_ff)
                        begin
                            addr_hit  = 1'b1;
                            hit_rw    = 1'b1;
                            nxt_state = ISF_SL_DATA;
                        end
                    end
                    else if (own7)
                    begin
                        addr_hit  = 1'b1;
                        hit_rw    = byte_v[0];
                        nxt_state = ISF_SL_DATA;
                    end
                end
            end
            ISF_SL_ADDR2:
            begin
                if (byte_p)
                begin
                    nxt_state = ISF_SL_SKIP;
                    if (ten_mode & (byte_v == own_ff[7:0])) // RQ15
                    begin
                        t10_hit   = 1'b1; // RQ5
                        addr_hit  = 1'b1;
                        nxt_state = ISF_SL_DATA;
                    end
                end
            end
            ISF_SL_IDLE, ISF_SL_DATA, ISF_SL_SKIP:
            begin
                nxt_state = state_ff;
            end
            default:
            begin
                nxt_state = ISF_SL_IDLE;
            end
        endcase
        // a master owns the bus, so address matching sleeps meanwhile
        if (start_p & ~master_mode_in)
        begin
            nxt_state = ISF_SL_ADDR;
        end
        if (stop_p | master_mode_in)
        begin
            nxt_state = ISF_SL_IDLE;
        end
    end

    // flag next values; every set wins over a clear in the same cycle
    wire slave_rx  = byte_p & (state_ff == ISF_SL_DATA) & ~rw_ff;
    wire slave_tx  = (state_ff == ISF_SL_DATA) & rw_ff;
    wire rx_byte   = slave_rx | (byte_p & master_rx_in);
    // a read in the same cycle frees the holding, so the byte still lands
    wire rx_load   = rx_byte & (~rbf_ff | rd_rx);
    wire ov_set    = rx_byte & rbf_ff & ~rd_rx; // RQ7
    wire tx_busy   = tx_busy_ff | tbf_ff;
    wire tx_accept = wr_tx & ~tx_busy;
    wire wcol_set  = wr_tx & tx_busy; // RQ6
    wire ack_end   = ack_p & tx_busy_ff;
    wire tx_done   = ack_end | (ack_p & slave_tx);
    wire bcl_set   = master_mode_in & sda_release_in & pins_f[1] &
                     ~pins_f[0]; // RQ3

    wire nxt_ack   = ack_end ? ack_v : ack_status_ff; // RQ1
    wire nxt_busy  = master_tx_start_in | (tx_busy_ff & ~ack_p); // RQ2
    wire nxt_bcl   = bcl_set | (bcl_ff & ~clr[BIT_BCL]); // RQ17
    wire nxt_gc    = gc_hit | (gc_ff & ~stop_p); // RQ4
    wire nxt_t10   = t10_hit | (t10_ff & ~stop_p); // RQ5
    wire nxt_wcol  = wcol_set | (wcol_ff & ~clr[BIT_WCOL]); // RQ6
    wire nxt_ov    = ov_set | (ov_ff & ~clr[BIT_OV]); // RQ7
    wire nxt_da    = slave_rx | (da_ff & ~addr_hit); // RQ8
    wire nxt_p     = stop_p | (p_ff & ~start_p & ~clr[BIT_P]); // RQ9
    wire nxt_s     = start_p | (s_ff & ~stop_p & ~clr[BIT_S]); // RQ10
    wire nxt_rw    = addr_hit ? hit_rw : rw_ff; // RQ11
    wire nxt_rbf   = rx_load | (rbf_ff & ~rd_rx); // RQ12
    wire nxt_tbf   = tx_accept | (tbf_ff & ~tx_done); // RQ13

    wire [EV_W-1:0] ev_set;
    assign ev_set[EV_START] = start_p;
    assign ev_set[EV_STOP]  = stop_p;
    assign ev_set[EV_RX]    = rx_load;
    assign ev_set[EV_BCL]   = bcl_set;
    assign ev_set[EV_WCOL]  = wcol_set;
    assign ev_set[EV_OV]    = ov_set;
    wire [EV_W-1:0] nxt_ev = ev_set | (ev_ff & ~{EV_W{rd_irq}});

    wire [31:0] status_word = {STATUS_HI_ZERO, ack_status_ff, tx_busy_ff,
                               STATUS_GAP_ZERO, bcl_ff, gc_ff, t10_ff,
                               wcol_ff, ov_ff, da_ff, p_ff, s_ff, rw_ff,
                               rbf_ff, tbf_ff}; // RQ14
    wire [31:0] nxt_rdata =
        ~reg_rd_in                       ? WORD_ZERO :
        (reg_addr_in == OFF_STATUS)      ? status_word :
        (reg_addr_in == OFF_CONTROL)     ? {30'h0, ctl_ff} :
        (reg_addr_in == OFF_OWN_ADDR)    ? {22'h0, own_ff} :
        (reg_addr_in == OFF_TX_HOLD)     ? {24'h0, tx_data_out} :
        (reg_addr_in == OFF_RX_HOLD)     ? {24'h0, rx_hold_ff} :
        (reg_addr_in == OFF_IRQ_STAT)    ? {26'h0, ev_ff} :
        (reg_addr_in == OFF_IRQ_MASK)    ? {26'h0, mask_ff} : WORD_ZERO;

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            {ack_status_ff, tx_busy_ff, bcl_ff, gc_ff, t10_ff} <= 5'h00;
            {wcol_ff, ov_ff, da_ff, p_ff, s_ff} <= 5'h00;
            {rw_ff, rbf_ff, tbf_ff} <= 3'h0;
            state_ff <= ISF_SL_IDLE;
        end
        else
        begin
            {ack_status_ff, tx_busy_ff, bcl_ff, gc_ff, t10_ff} <=
                {nxt_ack, nxt_busy, nxt_bcl, nxt_gc, nxt_t10};
            {wcol_ff, ov_ff, da_ff, p_ff, s_ff} <=
                {nxt_wcol, nxt_ov, nxt_da, nxt_p, nxt_s};
            {rw_ff, rbf_ff, tbf_ff} <= {nxt_rw, nxt_rbf, nxt_tbf};
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ctl_ff        <= 2'h0;
            own_ff        <= 10'h000;
            mask_ff       <= 6'h00;
            ev_ff         <= 6'h00;
            rx_hold_ff    <= 8'h00;
            tx_data_out   <= 8'h00;
            tx_full_out   <= 1'b0;
            reg_rdata_out <= WORD_ZERO;
            irq_out       <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
                ctl_ff <= reg_wdata_in[CTL_W-1:0];
            if (wr_own)
                own_ff <= reg_wdata_in[OWN_ADDR_W-1:0];
            if (wr_mask)
                mask_ff <= reg_wdata_in[EV_W-1:0];
            // holding keeps the unread byte on overflow
            if (rx_load)
                rx_hold_ff <= byte_v;
            if (tx_accept)
                tx_data_out <= reg_wdata_in[7:0]; // RQ6
            ev_ff         <= nxt_ev;
            tx_full_out   <= nxt_tbf;
            reg_rdata_out <= nxt_rdata;
            irq_out       <= |(nxt_ev & mask_ff);
        end
    end

    sequence s_tx_write_busy;
        wr_tx && tx_busy;
    endsequence
    sequence s_stop;
        stop_p;
    endsequence

    property p_ack;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        ack_end |=> ack_status_ff == $past(ack_v);
    endproperty
    a_ack: assert property (p_ack) else $error("ack result lost"); // RQ1

    property p_busy;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        tx_busy_ff && ack_p && !master_tx_start_in |=> !tx_busy_ff;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not ended"); // RQ2

    property p_bcl;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        bcl_ff && !clr[BIT_BCL] |=> bcl_ff;
    endproperty
    a_bcl: assert property (p_bcl) else $error("collision lost"); // RQ3

    property p_stop_clears;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        s_stop |=> !gc_ff && !t10_ff && p_ff && !s_ff;
    endproperty
    a_stop_clears: assert property (p_stop_clears) // RQ4
        else $error("stop did not update flags");

    property p_t10_mode;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        $rose(t10_ff) |-> $past(ten_mode);
    endproperty
    a_t10_mode: assert property (p_t10_mode) // RQ15
        else $error("ten bit match in seven bit mode");

    property p_wcol;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        s_tx_write_busy |=> wcol_ff && $stable(tx_data_out);
    endproperty
    a_wcol: assert property (p_wcol) else $error("busy write taken"); // RQ6

    property p_ov;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        rx_byte && rbf_ff && !rd_rx |=> ov_ff && $stable(rx_hold_ff);
    endproperty
    a_ov: assert property (p_ov) else $error("overflow missed"); // RQ7

    property p_start;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        start_p && !stop_p |=> s_ff && !p_ff;
    endproperty
    a_start: assert property (p_start) else $error("start flags"); // RQ10

    property p_rbf;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        rd_rx && !rx_load |=> !rbf_ff;
    endproperty
    a_rbf: assert property (p_rbf) else $error("read left full"); // RQ12

    property p_zero;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        reg_rd_in && reg_addr_in == OFF_STATUS
        |=> reg_rdata_out[31:16] == 16'h0000 && reg_rdata_out[13:11] == 3'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("reserved bits set"); // RQ14

    property p_general_call_enable;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        $rose(gc_ff) |-> $past(gc_en);
    endproperty
    a_general_call_enable: assert property (p_general_call_enable) else $error("general call off"); // RQ16
endmodule
`default_nettype wire

// [src/isf_pkg.sv]
`default_nettype none
package isf_pkg;
    // register offsets on the plain register port
    localparam logic [4:0]  OFF_STATUS    = 5'h00;
    localparam logic [4:0]  OFF_CONTROL   = 5'h04;
    localparam logic [4:0]  OFF_OWN_ADDR  = 5'h08;
    localparam logic [4:0]  OFF_TX_HOLD   = 5'h0C;
    localparam logic [4:0]  OFF_RX_HOLD   = 5'h10;
    localparam logic [4:0]  OFF_IRQ_STAT  = 5'h14;
    localparam logic [4:0]  OFF_IRQ_MASK  = 5'h18;
    // status bits that a write of zero clears
    localparam logic [15:0] STATUS_CLR_MASK = 16'h04D8;
    localparam logic [15:0] STATUS_HI_ZERO  = 16'h0000;
    localparam logic [2:0]  STATUS_GAP_ZERO = 3'h0;
    localparam int          BIT_BCL  = 10;
    localparam int          BIT_WCOL = 7;
    localparam int          BIT_OV   = 6;
    localparam int          BIT_P    = 4;
    localparam int          BIT_S    = 3;
    // control bits
    localparam int          CTL_TEN_BIT = 0;
    localparam int          CTL_GC_EN   = 1;
    localparam int          CTL_W       = 2;
    // interrupt event bits
    localparam int          EV_START = 0;
    localparam int          EV_STOP  = 1;
    localparam int          EV_RX    = 2;
    localparam int          EV_BCL   = 3;
    localparam int          EV_WCOL  = 4;
    localparam int          EV_OV    = 5;
    localparam int          EV_W     = 6;
    // address matching
    localparam int          OWN_ADDR_W = 10;
    localparam logic [7:0]  GC_ADDR    = 8'h00;
    localparam logic [4:0]  TEN_HDR    = 5'h1E;
    localparam logic [3:0]  BIT_LAST   = 4'h7;
    localparam logic [3:0]  BIT_ACK    = 4'h8;
    localparam logic [3:0]  BIT_ZERO   = 4'h0;
    localparam logic [3:0]  BIT_ONE    = 4'h1;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

    typedef enum logic [2:0] {
        ISF_SL_IDLE  = 3'h0,
        ISF_SL_ADDR  = 3'h1,
        ISF_SL_ADDR2 = 3'h3,
        ISF_SL_DATA  = 3'h2,
        ISF_SL_SKIP  = 3'h6
    } isf_slv_state_t;
endpackage
`default_nettype wire

// [src/isf_pin_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module isf_pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] level_out
);
    if (WIDTH < 1)
    begin : g_chk
        $error("isf_pin_sync needs at least one bit");
    end

    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        logic s1_ff;
        logic s2_ff;
        logic s3_ff;
        // idle bus level is high, so reset to one
        always_ff @(posedge ref_clk_in or negedge rstn_in)
        begin
            if (!rstn_in)
            begin
                s1_ff        <= 1'b1;
                s2_ff        <= 1'b1;
                s3_ff        <= 1'b1;
                level_out[i] <= 1'b1;
            end
            else
            begin
                s1_ff <= pin_in[i];
                s2_ff <= s1_ff;
                s3_ff <= s2_ff;
                if (s2_ff == s3_ff)
                begin
                    level_out[i] <= s3_ff;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [src/isf_bit_engine.sv]
`timescale 1ns/100ps
`default_nettype none
module isf_bit_engine
    import isf_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            start_out,
    output logic            stop_out,
    output logic            byte_out,
    output logic [7:0]      byte_val_out,
    output logic            ack_out,
    output logic            ack_val_out
);
    logic       scl_q_ff;
    logic       sda_q_ff;
    logic       active_ff;
    logic [3:0] cnt_ff;
    logic [7:0] shift_ff;

    wire scl_high = scl_in & scl_q_ff;
    wire is_start = scl_high & sda_q_ff & ~sda_in;
    wire is_stop  = scl_high & ~sda_q_ff & sda_in;
    wire rise     = scl_in & ~scl_q_ff & active_ff;
    wire at_last  = rise & (cnt_ff == BIT_LAST);
    wire at_ack   = rise & (cnt_ff == BIT_ACK);
    wire [3:0] nxt_cnt = (is_start | at_ack) ? BIT_ZERO :
                         rise ? cnt_ff + BIT_ONE : cnt_ff;

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            scl_q_ff     <= 1'b1;
            sda_q_ff     <= 1'b1;
            active_ff    <= 1'b0;
            cnt_ff       <= BIT_ZERO;
            shift_ff     <= 8'h00;
            start_out    <= 1'b0;
            stop_out     <= 1'b0;
            byte_out     <= 1'b0;
            byte_val_out <= 8'h00;
            ack_out      <= 1'b0;
            ack_val_out  <= 1'b0;
        end
        else
        begin
            scl_q_ff     <= scl_in;
            sda_q_ff     <= sda_in;
            active_ff    <= is_start | (active_ff & ~is_stop);
            cnt_ff       <= nxt_cnt;
            start_out    <= is_start;
            stop_out     <= is_stop;
            byte_out     <= at_last;
            ack_out      <= at_ack;
            if (rise & ~at_ack)
            begin
                shift_ff <= {shift_ff[6:0], sda_in};
            end
            if (at_last)
            begin
                byte_val_out <= {shift_ff[6:0], sda_in};
            end
            if (at_ack)
            begin
                ack_val_out <= sda_in;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/isf_bus_agent.sv]
`timescale 1ns/100ps
`default_nettype none
module isf_bus_agent (
    input  wire logic clk_in,
    output var  logic scl_out,
    output var  logic sda_out
);
    // pull-ups: both lines rest high, bus clock stands still between frames
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // half a bus clock of 160 ns is eight reference cycles
    task automatic put(input logic s, input logic d);
        repeat (8) @(posedge clk_in);
        scl_out <= s;
        sda_out <= d;
    endtask

    task automatic start_c();
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
    endtask

    task automatic stop_c();
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
    endtask

    // eight bits msb first, then the acknowledge bit, then release
    task automatic send_byte(input logic [7:0] v, input logic a);
        for (int i = 7; i >= 0; i--)
        begin
            put(1'b0, v[i]);
            put(1'b1, v[i]);
        end
        put(1'b0, a);
        put(1'b1, a);
        put(1'b0, a);
        put(1'b0, 1'b1);
    endtask
endmodule
`default_nettype wire

// [verification/test_i2c_status_flag_logic.sv]
`timescale 1ns/100ps
`default_nettype none
module test_i2c_status_flag_logic;
    import isf_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic        mmode = 1'b0;
    logic        mrx = 1'b0;
    logic        txs = 1'b0;
    logic        sda_rel = 1'b0;
    wire  [31:0] rdata;
    wire         irq;
    wire  [7:0]  tx_data;
    wire         tx_full;
    wire         scl;
    wire         sda;
    int          seed = 32'h0000_8f7e;
    int          miscompares = 0;
    int          compares = 0;
    logic [31:0] rd_val;
    logic [9:0]  own;
    logic [7:0]  d;

    always #5 ref_clk = ~ref_clk;

    isf_bus_agent bus (.clk_in(ref_clk), .scl_out(scl), .sda_out(sda));

    isf_status_flags uut (
        .ref_clk_in(ref_clk), .rstn_in(rstn), .scl_pin_in(scl),
        .sda_pin_in(sda), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .irq_out(irq), .master_mode_in(mmode), .master_rx_in(mrx),
        .master_tx_start_in(txs), .sda_release_in(sda_rel),
        .tx_data_out(tx_data), .tx_full_out(tx_full)
    );

    function automatic logic [31:0] bit_of(input int n);
        return 32'h0000_0001 << n;
    endfunction

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge ref_clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk);
        rd_s <= 1'b0;
        #1;
        rd_val = rdata;
    endtask

    // let the pin edge through the synchroniser before looking
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        repeat (8) @(posedge ref_clk);
        rd(OFF_STATUS);
        check("status", rd_val & m, e);
        check("unimpl", rd_val & 32'hFFFF_3800, 32'h0000_0000);
    endtask

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        conclude();
    end

    initial
    begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(OFF_STATUS);
        check("reset", rd_val, 32'h0000_0000);
        rd(5'h1C);
        check("unmapped", rd_val, 32'h0000_0000);
        own = 10'(($unsigned($random(seed)) % 96) + 8);
        wr(OFF_OWN_ADDR, {22'h0, own});
        wr(OFF_CONTROL, 32'h0000_0000);
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        bus.start_c();
        st(bit_of(BIT_S) | bit_of(BIT_P), bit_of(BIT_S));
        check("irq_masked", {31'h0, irq}, 32'h0000_0000);
        bus.send_byte({own[6:0], 1'b0}, 1'b1);
        st(bit_of(5) | bit_of(2) | bit_of(1), 32'h0000_0000);
        d = 8'($random(seed));
        bus.send_byte(d, 1'b1);
        st(bit_of(5) | bit_of(1) | bit_of(BIT_OV), bit_of(5) | bit_of(1));
        bus.send_byte(~d, 1'b1);
        st(bit_of(BIT_OV) | bit_of(1), bit_of(BIT_OV) | bit_of(1));
        rd(OFF_RX_HOLD);
        check("rx_hold", rd_val & 32'h0000_00FF, 32'(d));
        st(bit_of(1), 32'h0000_0000);
        bus.stop_c();
        st(bit_of(BIT_S) | bit_of(BIT_P), bit_of(BIT_P));
        wr(OFF_STATUS, ~bit_of(BIT_OV));
        st(bit_of(BIT_OV) | bit_of(BIT_P), bit_of(BIT_P));
        rd(OFF_IRQ_STAT);
        check("irq_early", rd_val, 32'h0000_0027);
        wr(OFF_IRQ_MASK, bit_of(EV_START));
        // pass 0: addressed read, general call off; pass 1: general call on
        for (int k = 0; k < 2; k++)
        begin
            wr(OFF_CONTROL, 32'(k) << CTL_GC_EN);
            bus.start_c();
            repeat (8) @(posedge ref_clk);
            check("irq_on", {31'h0, irq}, 32'h0000_0001);
            rd(OFF_IRQ_STAT);
            check("irq_stat", rd_val & bit_of(EV_START), bit_of(EV_START));
            repeat (2) @(posedge ref_clk);
            check("irq_off", {31'h0, irq}, 32'h0000_0000);
            bus.send_byte(k ? GC_ADDR : {own[6:0], 1'b1}, 1'b1);
            st(bit_of(9) | (k ? 0 : bit_of(2)), k ? bit_of(9) : bit_of(2));
            bus.stop_c();
            st(bit_of(9), 32'h0000_0000);
        end
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        own = 10'($random(seed));
        wr(OFF_OWN_ADDR, {22'h0, own});
        wr(OFF_CONTROL, bit_of(CTL_TEN_BIT));
        bus.start_c();
        bus.send_byte({TEN_HDR, own[9:8], 1'b0}, 1'b1);
        bus.send_byte(own[7:0], 1'b1);
        st(bit_of(8), bit_of(8));
        bus.stop_c();
        st(bit_of(8), 32'h0000_0000);
        @(posedge ref_clk);
        mmode <= 1'b1;
        bus.start_c();
        // nack then ack from the far slave
        for (int k = 1; k >= 0; k--)
        begin
            d = 8'($random(seed));
            wr(OFF_TX_HOLD, 32'(d));
            wr(OFF_TX_HOLD, 32'(~d));
            st(bit_of(BIT_WCOL) | bit_of(0), bit_of(BIT_WCOL) | bit_of(0));
            check("tx_data", 32'(tx_data), 32'(d));
            check("tx_full", {31'h0, tx_full}, 32'h0000_0001);
            @(posedge ref_clk);
            txs <= 1'b1;
            @(posedge ref_clk);
            txs <= 1'b0;
            st(bit_of(14), bit_of(14));
            bus.send_byte(d, k[0]);
            st(bit_of(15) | bit_of(14) | bit_of(0), k ? bit_of(15) : 0);
            check("tx_empty", {31'h0, tx_full}, 32'h0000_0000);
        end
        // master receive loads the holding register
        @(posedge ref_clk);
        mrx <= 1'b1;
        d = 8'($random(seed));
        bus.send_byte(d, 1'b0);
        st(bit_of(1), bit_of(1));
        rd(OFF_RX_HOLD);
        check("rx_master", rd_val & 32'h0000_00FF, 32'(d));
        @(posedge ref_clk);
        mrx <= 1'b0;
        bus.stop_c();
        @(posedge ref_clk);
        sda_rel <= 1'b1;
        bus.start_c();
        st(bit_of(BIT_BCL), bit_of(BIT_BCL));
        bus.stop_c();
        @(posedge ref_clk);
        sda_rel <= 1'b0;
        mmode <= 1'b0;
        st(bit_of(BIT_BCL), bit_of(BIT_BCL));
        wr(OFF_STATUS, ~bit_of(BIT_BCL));
        st(bit_of(BIT_BCL) | bit_of(BIT_WCOL), bit_of(BIT_WCOL));
        rd(OFF_IRQ_STAT);
        check("irq_events", rd_val, 32'h0000_001F);
        conclude();
    end
endmodule
`default_nettype wire
